// ### hw/vpcr_bank.sv
/*
 * register bank of the first-stage jitter-attenuator loop: feedback
 * divider bypass, loop bypass, oscillator polarity, control-voltage force
 * to midpoint, pump current code, plus stored output and second pump fields.
 * assumes: the serial configuration engine runs on core_clk and presents
 * byte writes and reads through regAddr, regWrEn, regRdEn.
 */
`timescale 1ns/1ps
`include "vpcr_consts.svh"

module vpcr_bank #(
  parameter int FIRST_DIV_W = 12,
  parameter int SECOND_DIV_W = 9
) (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic [7:0] regAddr, // register byte address
  input wire logic [7:0] regWdata, // write data
  input wire logic regWrEn, // write strobe, one cycle
  input wire logic regRdEn, // read strobe, one cycle
  output logic [7:0] regRdata_r, // read data, valid cycle after strobe
  input wire logic [FIRST_DIV_W-1:0] firstFeedbackDivider, // first divider value
  input wire logic [SECOND_DIV_W-2:0] secondFeedbackDividerLow, // second divider low bits
  output logic feedbackDividerBypass_r, // 1: product of both dividers
  output logic [FIRST_DIV_W+SECOND_DIV_W-1:0] loopDivisor_r, // active feedback ratio
  output logic firstLoopBypass_r, // 1: loop disabled and bypassed
  output logic firstLoopEnable_r, // 1: loop running
  output logic oscillatorPolarity_r, // 1: negative loop sense
  output logic forceControlMidpoint_r, // 1: control pin held at half supply
  output logic [4:0] firstPumpCurrentCode_r, // pump current code
  output logic [10:0] firstPumpCurrent_r, // pump current in microamps
  output logic [7:0] oscOutputOffset_r, // power, format, offset fields
  output logic [7:0] ampSecondPump_r // amplitude and second pump fields
);

  vpcr_pkg::vpcr_state_s cur;
  vpcr_pkg::vpcr_state_s nxt;
  logic [SECOND_DIV_W-1:0] secondDiv;
  logic [4:0] codeNxt;
  logic [FIRST_DIV_W+SECOND_DIV_W-1:0] product;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt = cur;
    if (regWrEn) begin
      case (regAddr)
        `VPCR_OFF_FB_BYPASS: nxt.fbBypassReg = regWdata & `VPCR_MASK_FB_BYPASS;
        `VPCR_OFF_LOOP_BYPASS: nxt.loopBypassReg = regWdata & `VPCR_MASK_LOOP_BYPASS;
        // force bit cleared here by software once startup is done
        `VPCR_OFF_POL_FORCE_PUMP: nxt.polForcePumpReg = regWdata & `VPCR_MASK_POL_FORCE_PUMP;
        `VPCR_OFF_OSC_OUT_OFFSET: nxt.oscOutOffsetReg = regWdata & `VPCR_MASK_OSC_OUT_OFFSET;
        `VPCR_OFF_AMP_SECOND_PUMP: nxt.ampSecondPumpReg = regWdata & `VPCR_MASK_AMP_SECOND_PUMP;
        default: nxt.rdData = cur.rdData;
      endcase
    end
    if (regRdEn) begin
      case (regAddr)
        `VPCR_OFF_FB_BYPASS: nxt.rdData = cur.fbBypassReg;
        `VPCR_OFF_LOOP_BYPASS: nxt.rdData = cur.loopBypassReg;
        `VPCR_OFF_POL_FORCE_PUMP: nxt.rdData = cur.polForcePumpReg;
        `VPCR_OFF_OSC_OUT_OFFSET: nxt.rdData = cur.oscOutOffsetReg;
        `VPCR_OFF_AMP_SECOND_PUMP: nxt.rdData = cur.ampSecondPumpReg;
        default: nxt.rdData = `VPCR_RD_UNMAPPED;
      endcase
    end
    // run flag kept as its own flop so the output needs no inverter
    nxt.loopEnable = ~nxt.loopBypassReg[`VPCR_BIT_LOOP_BYPASS];
    // pump current follows the stored code: step times code plus one
    codeNxt = nxt.polForcePumpReg[`VPCR_PUMP_MSB:`VPCR_PUMP_LSB];
    nxt.pumpCurrentUa = 11'(`VPCR_PUMP_STEP_UA * ({6'h00, codeNxt} + 11'h001));
    // feedback ratio: first divider alone or times the second
    secondDiv = {nxt.fbBypassReg[`VPCR_BIT_SECOND_DIV_MSB], secondFeedbackDividerLow};
    product = (FIRST_DIV_W+SECOND_DIV_W)'(firstFeedbackDivider) *
              (FIRST_DIV_W+SECOND_DIV_W)'(secondDiv);
    if (nxt.fbBypassReg[`VPCR_BIT_FB_BYPASS]) begin
      nxt.loopDivisor = 30'(product);
    end else begin
      nxt.loopDivisor = 30'(firstFeedbackDivider);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cur.fbBypassReg <= `VPCR_RST_FB_BYPASS;
      cur.loopBypassReg <= `VPCR_RST_LOOP_BYPASS;
      cur.loopEnable <= `VPCR_RST_LOOP_ENABLE;
      cur.polForcePumpReg <= `VPCR_RST_POL_FORCE_PUMP;
      cur.oscOutOffsetReg <= `VPCR_RST_OSC_OUT_OFFSET;
      cur.ampSecondPumpReg <= `VPCR_RST_AMP_SECOND_PUMP;
      cur.rdData <= `VPCR_RD_UNMAPPED;
      cur.pumpCurrentUa <= `VPCR_RST_PUMP_UA; // 1250 uA, matches reset code
      cur.loopDivisor <= 30'h00000000;
    end else begin
      cur <= nxt;
    end
  end

  // ****************************************
  // outputs, all straight from the state
  // ****************************************
  always_comb begin
    regRdata_r = cur.rdData;
    feedbackDividerBypass_r = cur.fbBypassReg[`VPCR_BIT_FB_BYPASS];
    loopDivisor_r = (FIRST_DIV_W+SECOND_DIV_W)'(cur.loopDivisor);
    firstLoopBypass_r = cur.loopBypassReg[`VPCR_BIT_LOOP_BYPASS];
    firstLoopEnable_r = cur.loopEnable;
    oscillatorPolarity_r = cur.polForcePumpReg[`VPCR_BIT_POLARITY];
    forceControlMidpoint_r = cur.polForcePumpReg[`VPCR_BIT_FORCE_MID];
    firstPumpCurrentCode_r = cur.polForcePumpReg[`VPCR_PUMP_MSB:`VPCR_PUMP_LSB];
    firstPumpCurrent_r = cur.pumpCurrentUa;
    oscOutputOffset_r = cur.oscOutOffsetReg;
    ampSecondPump_r = cur.ampSecondPumpReg;
  end

endmodule

// ### hw/vpcr_consts.svh
/*
 * offsets, field positions, write masks, reset values and pump scaling
 * for the first-stage loop control register bank.
 * assumes: included by bare name from the bank module only.
 */
`ifndef VPCR_CONSTS_SVH
`define VPCR_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define VPCR_OFF_FB_BYPASS 8'h03
`define VPCR_OFF_LOOP_BYPASS 8'h0A
`define VPCR_OFF_POL_FORCE_PUMP 8'h10
`define VPCR_OFF_OSC_OUT_OFFSET 8'h11
`define VPCR_OFF_AMP_SECOND_PUMP 8'h12

// ****************************************
// field positions
// ****************************************
`define VPCR_BIT_FB_BYPASS 0
`define VPCR_BIT_SECOND_DIV_MSB 7
`define VPCR_BIT_LOOP_BYPASS 0
`define VPCR_BIT_POLARITY 7
`define VPCR_BIT_FORCE_MID 6
`define VPCR_PUMP_MSB 4
`define VPCR_PUMP_LSB 0

// ****************************************
// writable bits, reserved bits are zero here
// ****************************************
`define VPCR_MASK_FB_BYPASS 8'h81
`define VPCR_MASK_LOOP_BYPASS 8'h01
`define VPCR_MASK_POL_FORCE_PUMP 8'hDF
`define VPCR_MASK_OSC_OUT_OFFSET 8'hFF
`define VPCR_MASK_AMP_SECOND_PUMP 8'h7F

// ****************************************
// reset values
// ****************************************
`define VPCR_RST_FB_BYPASS 8'h00
`define VPCR_RST_LOOP_BYPASS 8'h00
`define VPCR_RST_POL_FORCE_PUMP 8'h58
`define VPCR_RST_OSC_OUT_OFFSET 8'h00
`define VPCR_RST_AMP_SECOND_PUMP 8'h00
`define VPCR_RD_UNMAPPED 8'h00
`define VPCR_RST_PUMP_UA 11'h4E2
`define VPCR_RST_LOOP_ENABLE 1'b1

// ****************************************
// pump current step in microamps
// ****************************************
`define VPCR_PUMP_STEP_UA 11'h032

`endif

// ### hw/vpcr_pkg.sv
/*
 * types for the first-stage loop control register bank.
 * assumes: nothing beyond the constants header.
 */
package vpcr_pkg;

  // ****************************************
  // whole state of the bank
  // ****************************************
  typedef struct packed {
    logic [7:0] fbBypassReg;
    logic [7:0] loopBypassReg;
    logic loopEnable;
    logic [7:0] polForcePumpReg;
    logic [7:0] oscOutOffsetReg;
    logic [7:0] ampSecondPumpReg;
    logic [7:0] rdData;
    logic [10:0] pumpCurrentUa;
    logic [29:0] loopDivisor;
  } vpcr_state_s;

endpackage

// ### test/vpcr_bank_assertions.sv
/* checker for the loop control bank
   assumes: bound to every vpcr_bank, one clock core_clk */
`timescale 1ns/1ps
module vpcr_bank_assertions #(
  parameter int FIRST_DIV_W = 12,
  parameter int SECOND_DIV_W = 9
) (
  input logic core_clk, // clock
  input logic rstn, // sync reset, active low
  input logic [7:0] regAddr, // address
  input logic [7:0] regWdata, // write data
  input logic regWrEn, // write strobe
  input logic [FIRST_DIV_W-1:0] firstFeedbackDivider, // first divider
  input logic feedbackDividerBypass_r, // divider bypass
  input logic [FIRST_DIV_W+SECOND_DIV_W-1:0] loopDivisor_r, // ratio
  input logic firstLoopBypass_r, // loop bypass
  input logic firstLoopEnable_r, // loop running
  input logic oscillatorPolarity_r, // polarity
  input logic forceControlMidpoint_r, // force midpoint
  input logic [4:0] firstPumpCurrentCode_r, // pump code
  input logic [10:0] firstPumpCurrent_r, // pump current
  input logic [7:0] ampSecondPump_r // amplitude field
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence wr(a); regWrEn && regAddr == a; endsequence
  divSel_a: assert property ($past(rstn) && !feedbackDividerBypass_r
    |-> loopDivisor_r == $past(firstFeedbackDivider)) else $error("divisor wrong");
  fbWrite_a: assert property (wr(8'h03)
    |=> feedbackDividerBypass_r == $past(regWdata[0])) else $error("bypass bit wrong");
  loopByp_a: assert property (wr(8'h0A)
    |=> firstLoopBypass_r == $past(regWdata[0])) else $error("loop bypass wrong");
  loopRun_a: assert property (firstLoopEnable_r != firstLoopBypass_r)
    else $error("loop run flag wrong");
  polForce_a: assert property (wr(8'h10)
    |=> {oscillatorPolarity_r, forceControlMidpoint_r} == $past(regWdata[7:6]))
    else $error("polarity or force wrong");
  pumpCode_a: assert property (wr(8'h10)
    |=> firstPumpCurrentCode_r == $past(regWdata[4:0])) else $error("pump code wrong");
  pumpCur_a: assert property (
    firstPumpCurrent_r == 11'h032 * (firstPumpCurrentCode_r + 11'h001))
    else $error("pump current wrong");
  resetVal_a: assert property ($rose(rstn)
    |-> forceControlMidpoint_r && !oscillatorPolarity_r && !firstLoopBypass_r
    && firstPumpCurrentCode_r == 5'h18) else $error("reset value wrong");
  rsvdAmp_a: assert property (!ampSecondPump_r[7]) else $error("reserved bit set");
endmodule
bind vpcr_bank vpcr_bank_assertions #(
  .FIRST_DIV_W(FIRST_DIV_W),
  .SECOND_DIV_W(SECOND_DIV_W)
) uChk (
  .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrEn(regWrEn),
  .firstFeedbackDivider(firstFeedbackDivider), .feedbackDividerBypass_r(feedbackDividerBypass_r),
  .loopDivisor_r(loopDivisor_r), .firstLoopBypass_r(firstLoopBypass_r),
  .firstLoopEnable_r(firstLoopEnable_r), .oscillatorPolarity_r(oscillatorPolarity_r),
  .forceControlMidpoint_r(forceControlMidpoint_r), .firstPumpCurrentCode_r(firstPumpCurrentCode_r),
  .firstPumpCurrent_r(firstPumpCurrent_r), .ampSecondPump_r(ampSecondPump_r));

// ### test/vpcr_bank_tb_top.sv
/* bench for the loop control bank: reset, walk, reserved bits, divider
   assumes: the bank and its checker are compiled before it */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module vpcr_bank_tb_top;
  logic core_clk = 0, rstn = 0, regWrEn = 0, regRdEn = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata_r;
  logic [11:0] firstDiv = 12'h00C;
  logic [7:0] secondLow = 8'h05;
  logic fbByp, loopByp, loopEn, pol, frc;
  logic [4:0] code;
  logic [10:0] cur;
  logic [20:0] div;
  logic [7:0] oscOut, amp;
  logic [7:0] adr [6] = '{8'h03, 8'h0A, 8'h10, 8'h11, 8'h12, 8'h04};
  int checks = 0, err_count = 0, cyc = 0;
  vpcr_bank dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdata_r(regRdata_r),
    .firstFeedbackDivider(firstDiv), .secondFeedbackDividerLow(secondLow),
    .feedbackDividerBypass_r(fbByp), .loopDivisor_r(div), .firstLoopBypass_r(loopByp),
    .firstLoopEnable_r(loopEn), .oscillatorPolarity_r(pol), .forceControlMidpoint_r(frc),
    .firstPumpCurrentCode_r(code), .firstPumpCurrent_r(cur), .oscOutputOffset_r(oscOut),
    .ampSecondPump_r(amp));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  // one strobe cycle, read data settled on return
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    #1 regAddr = a;
    regWdata = d;
    regWrEn = w;
    regRdEn = !w;
    @(posedge core_clk);
    #1 regWrEn = 0;
    regRdEn = 0;
  endtask
  task automatic readAll(input logic [7:0] e [6]);
    for (int i = 0; i < 6; i++) begin
      bus(0, adr[i], 8'h00);
      `CHK("read", e[i], regRdata_r)
    end
  endtask
  task automatic t_reset();
    readAll('{8'h00, 8'h00, 8'h58, 8'h00, 8'h00, 8'h00});
    `CHK("current", 11'h4E2, cur)
    `CHK("force", 1'b1, frc)
    $display("reset test done");
  endtask
  task automatic t_walk();
    bus(1, 8'h10, 8'h1F);
    `CHK("force", 1'b0, frc)
    `CHK("polarity", 1'b0, pol)
    `CHK("code", 5'h1F, code)
    `CHK("current", 11'h640, cur)
    bus(1, 8'h10, 8'hC0);
    `CHK("polarity", 1'b1, pol)
    `CHK("force", 1'b1, frc)
    `CHK("code", 5'h00, code)
    `CHK("current", 11'h032, cur)
    $display("walk test done");
  endtask
  task automatic t_rsvd();
    for (int i = 0; i < 6; i++) bus(1, adr[i], 8'hFF);
    readAll('{8'h81, 8'h01, 8'hDF, 8'hFF, 8'h7F, 8'h00});
    `CHK("loop bypass", 1'b1, loopByp)
    `CHK("loop run", 1'b0, loopEn)
    `CHK("output fields", 8'hFF, oscOut)
    `CHK("amplitude fields", 8'h7F, amp)
    `CHK("fb bypass", 1'b1, fbByp)
    `CHK("divisor", 21'h000C3C, div)
    bus(1, 8'h03, 8'h00);
    `CHK("fb bypass", 1'b0, fbByp)
    @(posedge core_clk);
    #1 `CHK("divisor", 21'h00000C, div)
    $display("reserved and divider test done");
  endtask
  task automatic t_rereset();
    @(posedge core_clk);
    #1 rstn = 0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1;
    `CHK("loop bypass", 1'b0, loopByp)
    `CHK("loop run", 1'b1, loopEn)
    `CHK("polarity", 1'b0, pol)
    `CHK("force", 1'b1, frc)
    `CHK("code", 5'h18, code)
    `CHK("current", 11'h4E2, cur)
    `CHK("amplitude fields", 8'h00, amp)
    @(posedge core_clk);
    #1 `CHK("divisor", 21'h00000C, div)
    $display("mid-run reset test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rstn = 1;
    t_reset();
    t_walk();
    t_rsvd();
    t_rereset();
    finish_test();
  end
endmodule
